//--- core/ses_map.svh
// ses_map.svh - offsets, fields, reset values and timing counts.
// assumes a 100 MHz core clock; included by bare name from design files.
`ifndef SES_MAP_SVH
`define SES_MAP_SVH

// ==========
// timing
`define SES_CLK_NS        10
`define SES_TRIG_MIN_NS   1000
`define SES_TRIG_MIN_CYC  ((`SES_TRIG_MIN_NS + `SES_CLK_NS - 1) / `SES_CLK_NS)

// ==========
// register byte offsets
`define SES_OFF_CTRL      8'h00
`define SES_OFF_EXPO      8'h04
`define SES_OFF_LTIME     8'h08
`define SES_OFF_LINES     8'h0c
`define SES_OFF_DUMMY     8'h10
`define SES_OFF_EDLY      8'h14
`define SES_OFF_FLASH     8'h18
`define SES_OFF_ROI       8'h1c
`define SES_OFF_STAT      8'h20
`define SES_OFF_MINPER    8'h24
`define SES_OFF_FRTIME    8'h28

// ==========
// fields
`define SES_F_MODE        1:0
`define SES_F_PW          2
`define SES_F_FLEN        3
`define SES_F_EN          4
`define SES_CTRL_W        5
`define SES_F_ROI_FIRST   15:0
`define SES_F_ROI_CNT     31:16
`define SES_ST_DROP       2

// ==========
// reset values
`define SES_RST_CTRL      5'h00
`define SES_RST_EXPO      32'h0000_03e8
`define SES_RST_LTIME     16'h0064
`define SES_RST_LINES     16'h0010
`define SES_RST_DUMMY     16'h0002
`define SES_RST_EDLY      16'h000a
`define SES_RST_FLASH     32'h0000_0064
`define SES_RST_ROI       32'h0010_0000

`endif

//--- core/ses_pkg.sv
// ses_pkg - types shared by the sequencer files.
// assumes nothing beyond a SystemVerilog compiler.
package ses_pkg;

    // ==========
    // shutter regime, as held in the control register
    typedef enum logic [1:0] {
        SES_GLOBAL  = 2'h0,
        SES_ROLLING = 2'h1,
        SES_GRR     = 2'h2,
        SES_RSV     = 2'h3
    } ses_mode_t;

    // ==========
    // exposure engine states, one-hot
    typedef enum logic [4:0] {
        SES_EX_IDLE   = 5'h01,
        SES_EX_WAIT   = 5'h02,
        SES_EX_DELAY  = 5'h04,
        SES_EX_EXPOSE = 5'h08,
        SES_EX_HOLD   = 5'h10
    } ses_ex_t;

endpackage : ses_pkg

//--- core/ses_tick.sv
// ses_tick - loadable down-counter, pulses when its count runs out.
// assumes load is a one-cycle pulse; a value of zero behaves as one.
`timescale 1ns/1ps
module ses_tick #(
    parameter int W = 16
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         load,
    input  wire logic [W-1:0] val,
    output logic              busy,
    output logic              done
);
    logic [W-1:0] cnt_q;
    logic         run_q;
    wire          last = (cnt_q <= W'(1));

    if (W < 2) begin : g_chk
        $error("ses_tick: W must be at least 2");
    end

    // reload wins over expiry so a timer can restart in its done cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q  <= '0;
            run_q  <= 1'b0;
        end else begin
            if (load) begin
                cnt_q <= val;
                run_q <= 1'b1;
            end else if (run_q) begin
                cnt_q <= cnt_q - W'(1);
                run_q <= ~last;
            end
        end
    end

    assign busy = run_q;
    // done in the last counted cycle, so a count of n spans n cycles
    assign done = run_q & last;
endmodule : ses_tick

//--- core/ses_edge.sv
// ses_edge - registers a synchronous level and flags its rising and
// falling edges for one cycle.
// assumes the input is already synchronous to pclk.
`timescale 1ns/1ps
module ses_edge (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic lvl,
    output logic      rise,
    output logic      fall
);
    logic prev_q;

    // previous level, low after reset so a high input counts as an edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= lvl;
        end
    end

    assign rise = lvl & ~prev_q;
    assign fall = ~lvl & prev_q;
endmodule : ses_edge

//--- core/ses_seq.sv
// ses_seq - exposure and readout sequencer for an area sensor, with an
// apb slave, trigger input, flash strobe and line controls.
// assumes trig_in synchronous to pclk and a sensor that acts on one-cycle
// reset, transfer and read pulses carrying a row index.
//
// Function
// R1 - global: common pixel reset, common start and end
// R2 - global: readout starts after whole-frame exposure
// R3 - rolling: each line reset and started at its own time
// R4 - rolling: line read right after its exposure
// R5 - rolling: no line restarts before it was read
// R6 - pulse-width exposure refused outside global mode
// R7 - rolling scans all lines; roi only narrows line_valid
// R8 - min period = lines x line time + delay; plus exposure
// R9 - reset-release: all lines reset and start together
// R10 - reset-release: integration ends line by line at readout
// R11 - reset-release: next integration waits for readout end
// R12 - reset-release flash starts with exposure, stays inside it
// R13 - rolling flash delayed one scan; exposure covers scan+flash
// R14 - light controller keeps light for scan plus exposure; flash_strobe here stays on for the flash time only
// R15 - trigger modes: pulse-width or programmed, overlapped or not
// R16 - exposure starts on trigger rising edge
// R17 - overlap aligns to line_valid fall, else fixed delay
// R18 - shutter mode applies from next triggered frame
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "ses_map.svh"
module ses_seq import ses_pkg::*; #(
    parameter int LW = 16,
    parameter int AW = 8
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [31:0]   pwdata,
    output logic               pready,
    output logic [31:0]        prdata,
    output logic               pslverr,
    input  wire logic          trig_in,
    output logic               pix_reset_all,
    output logic               xfer_all,
    output logic               line_reset,
    output logic [LW-1:0]      line_reset_row,
    output logic               line_read,
    output logic [LW-1:0]      line_read_row,
    output logic               frame_valid,
    output logic               line_valid,
    output logic               flash_strobe,
    output logic               expose_active
);
    localparam int TW = 2 * LW;

    if (LW < 2 || LW > 16 || AW < 6) begin : g_chk
        $error("ses_seq: LW must be 2..16 and AW at least 6");
    end

    // ==========
    // registers
    logic [`SES_CTRL_W-1:0] ctrl_q;
    logic [TW-1:0]          expo_q, flt_q;
    logic [LW-1:0]          lt_q, lines_q, dummy_q, edly_q;
    logic [31:0]            roi_q;
    logic                   drop_q;
    logic [15:0]            frames_q;
    logic                   pready_q, pslverr_q;
    logic [31:0]            prdata_q;
    ses_ex_t                ex_q, ex_d;
    ses_mode_t              mode_q;
    logic                   pw_q, exp_fin_q, fl_dly_q, fl_on_q;
    logic                   rd_busy_q, walk_q, lv_q, lrd_q, lrs_q;
    logic [LW-1:0]          rd_ptr_q, rs_ptr_q, rd_row_q, rs_row_q;
    logic                   pixrst_q, xfer_q, expact_q;

    // ==========
    // apb decode; one wait-free access, answer ready in the access phase
    wire setup   = psel & ~penable & ~pready_q;
    wire access  = psel & penable & pready_q;
    wire wr      = access & pwrite & ~pslverr_q;
    wire [7:0] a8 = paddr[7:0];
    wire s_ctrl  = (a8 == `SES_OFF_CTRL);
    wire s_expo  = (a8 == `SES_OFF_EXPO);
    wire s_lt    = (a8 == `SES_OFF_LTIME);
    wire s_lines = (a8 == `SES_OFF_LINES);
    wire s_dummy = (a8 == `SES_OFF_DUMMY);
    wire s_edly  = (a8 == `SES_OFF_EDLY);
    wire s_flash = (a8 == `SES_OFF_FLASH);
    wire s_roi   = (a8 == `SES_OFF_ROI);
    wire s_stat  = (a8 == `SES_OFF_STAT);
    wire s_minp  = (a8 == `SES_OFF_MINPER);
    wire s_frt   = (a8 == `SES_OFF_FRTIME);
    wire hi_zero = (AW > 8) ? (paddr >> 8) == '0 : 1'b1;
    wire hit     = hi_zero & (s_ctrl | s_expo | s_lt | s_lines | s_dummy
                   | s_edly | s_flash | s_roi | s_stat | s_minp | s_frt);

    // ==========
    // derived timing: scan of every line, frame period and frame time
    wire [LW-1:0] tot_lines = LW'(lines_q + dummy_q);              // [R7]
    wire [TW-1:0] scan_cyc  = {{LW{1'b0}}, tot_lines}
                              * {{LW{1'b0}}, lt_q};                  // [R8]
    wire [TW-1:0] min_per   = TW'(scan_cyc + TW'(edly_q));           // [R8]
    wire [TW-1:0] frame_t   = TW'(min_per + expo_q);                 // [R8]
    wire [LW-1:0] roi_first = roi_q[`SES_F_ROI_FIRST];
    wire [LW-1:0] roi_cnt   = roi_q[`SES_F_ROI_CNT];

    // configuration view; the reserved code falls back to global
    wire [1:0]    mode_bits = ctrl_q[`SES_F_MODE];
    wire ses_mode_t mode_cfg = (mode_bits == SES_RSV) ? SES_GLOBAL
                               : ses_mode_t'(mode_bits);
    wire          en        = ctrl_q[`SES_F_EN];
    wire          fl_en     = ctrl_q[`SES_F_FLEN];
    wire          pw_ign    = ctrl_q[`SES_F_PW] & (mode_cfg != SES_GLOBAL);
    wire [TW-1:0] scan_fl   = TW'(scan_cyc + flt_q);
    wire          cfg_err   = fl_en & ((mode_cfg == SES_ROLLING)
                              ? (expo_q < scan_fl)                   // [R13]
                              : (mode_cfg == SES_GRR) & (flt_q >= expo_q));

    // status word read back by software
    wire [31:0] stat_w = {frames_q, 11'h000, cfg_err, pw_ign, drop_q,
                          rd_busy_q, (ex_q != SES_EX_IDLE)};
    wire [31:0] rd_word =
          s_ctrl  ? 32'(ctrl_q)  : s_expo  ? 32'(expo_q)
        : s_lt    ? 32'(lt_q)    : s_lines ? 32'(lines_q)
        : s_dummy ? 32'(dummy_q) : s_edly  ? 32'(edly_q)
        : s_flash ? 32'(flt_q)   : s_roi   ? roi_q
        : s_stat  ? stat_w       : s_minp  ? 32'(min_per)
        : s_frt   ? 32'(frame_t) : 32'h0000_0000;

    // ==========
    // trigger and line_valid edges
    logic trig_rise, lv_fall;
    ses_edge u_trig (
        .pclk    (pclk),
        .presetn (presetn),
        .lvl     (trig_in),
        .rise    (trig_rise),
        .fall    ()
    );
    ses_edge u_lv (
        .pclk    (pclk),
        .presetn (presetn),
        .lvl     (lv_q),
        .rise    (),
        .fall    (lv_fall)
    );

    // ==========
    // timers: exposure/delay, line period and flash
    logic ex_busy, ex_done, lt_busy, lt_done, fl_busy, fl_done;

    // overlap only when running and new frame are both global
    wire overlap_ok = (mode_cfg == SES_GLOBAL) & (mode_q == SES_GLOBAL);
    wire accept     = trig_rise & en & (ex_q == SES_EX_IDLE)
                      & (~rd_busy_q | overlap_ok);                   // [R16]
    wire dly_go     = accept & ~rd_busy_q;                           // [R17]
    wire expo_go    = ((ex_q == SES_EX_WAIT) & (lv_fall | ~rd_busy_q))
                      | ((ex_q == SES_EX_DELAY) & ex_done);          // [R17]
    wire exp_end    = exp_fin_q & (~pw_q | ~trig_in);                // [R15]
    wire hold_ok    = (mode_q == SES_GLOBAL) ? ~rd_busy_q            // [R2]
                    : (mode_q == SES_ROLLING) ? lt_done : 1'b1;      // [R4]
    wire rd_start   = (ex_q == SES_EX_HOLD) & hold_ok;
    wire in_exp     = (ex_q == SES_EX_EXPOSE) | (ex_q == SES_EX_HOLD);
    wire keep_run   = walk_q | rd_busy_q | in_exp;

    wire          ex_load = dly_go | expo_go;
    wire [TW-1:0] ex_val  = dly_go ? TW'(edly_q)
                          : pw_q   ? TW'(`SES_TRIG_MIN_CYC) : expo_q;
    ses_tick #(.W(TW)) u_ex (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (ex_load),
        .val     (ex_val),
        .busy    (ex_busy),
        .done    (ex_done)
    );

    // line period runs while any line activity is pending
    wire lt_load = ((expo_go | rd_start) & ~lt_busy) | (lt_done & keep_run);
    ses_tick #(.W(LW)) u_lt (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (lt_load),
        .val     (lt_q),
        .busy    (lt_busy),
        .done    (lt_done)
    );

    // rolling flash waits one scan, others start with exposure
    wire          roll_now = (mode_q == SES_ROLLING);
    wire          fl_load  = (expo_go & fl_en) | (fl_done & fl_dly_q);
    wire [TW-1:0] fl_val   = (expo_go & roll_now) ? scan_cyc : flt_q; // [R13]
    ses_tick #(.W(TW)) u_fl (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (fl_load),
        .val     (fl_val),
        .busy    (fl_busy),
        .done    (fl_done)
    );

    // ==========
    // exposure engine next state
    always_comb begin
        ex_d = ex_q;
        unique case (ex_q)
            SES_EX_IDLE: begin
                if (accept) begin
                    ex_d = rd_busy_q ? SES_EX_WAIT : SES_EX_DELAY;
                end
            end
            SES_EX_WAIT, SES_EX_DELAY: begin
                if (expo_go) begin
                    ex_d = SES_EX_EXPOSE;
                end
            end
            SES_EX_EXPOSE: begin
                if (exp_end) begin
                    ex_d = SES_EX_HOLD;
                end
            end
            SES_EX_HOLD: begin
                if (hold_ok) begin
                    ex_d = SES_EX_IDLE;
                end
            end
            default: ex_d = SES_EX_IDLE;
        endcase
    end

    // ==========
    // readout row and roi check; rows outside roi are still scanned
    wire [LW-1:0] rd_row  = rd_start ? '0 : rd_ptr_q;
    wire [LW-1:0] roi_end = LW'(roi_first + roi_cnt);
    wire          in_roi  = (rd_row >= roi_first) & (rd_row < roi_end)
                            & (rd_row < lines_q);                    // [R7]
    wire          rd_last = rd_busy_q & lt_done & (rd_ptr_q >= tot_lines);
    wire          rd_step = rd_start | (rd_busy_q & lt_done & ~rd_last);
    wire          rs_last = walk_q & lt_done & (rs_ptr_q >= tot_lines);
    wire          rs_go   = expo_go & (mode_q == SES_ROLLING);

    // ==========
    // apb slave and software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup & ~hit;
            prdata_q  <= (setup & hit & ~pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    // mode is sampled at trigger time, so mode writes never
    // tear a running frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q  <= `SES_RST_CTRL;
            expo_q  <= `SES_RST_EXPO;
            lt_q    <= `SES_RST_LTIME;
            lines_q <= `SES_RST_LINES;
            dummy_q <= `SES_RST_DUMMY;
            edly_q  <= `SES_RST_EDLY;
            flt_q   <= `SES_RST_FLASH;
            roi_q   <= `SES_RST_ROI;
        end else if (wr) begin
            if (s_ctrl)  ctrl_q  <= pwdata[`SES_CTRL_W-1:0];         // [R18]
            if (s_expo)  expo_q  <= pwdata[TW-1:0];
            if (s_lt)    lt_q    <= pwdata[LW-1:0];
            if (s_lines) lines_q <= pwdata[LW-1:0];
            if (s_dummy) dummy_q <= pwdata[LW-1:0];
            if (s_edly)  edly_q  <= pwdata[LW-1:0];
            if (s_flash) flt_q   <= pwdata[TW-1:0];
            if (s_roi)   roi_q   <= pwdata;
        end
    end

    // dropped-trigger flag: a new drop beats a same-cycle clear
    wire drop_set = trig_rise & en & ~accept;
    wire drop_clr = wr & s_stat & pwdata[`SES_ST_DROP];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drop_q   <= 1'b0;
            frames_q <= 16'h0000;
        end else begin
            drop_q   <= drop_set | (drop_q & ~drop_clr);
            frames_q <= rd_last ? frames_q + 16'h0001 : frames_q;
        end
    end

    // ==========
    // exposure engine; mode and pulse-width choice latched per frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ex_q      <= SES_EX_IDLE;
            mode_q    <= SES_GLOBAL;
            pw_q      <= 1'b0;
            exp_fin_q <= 1'b0;
        end else begin
            ex_q <= ex_d;
            if (accept) begin
                mode_q <= mode_cfg;                                  // [R18]
                pw_q   <= ctrl_q[`SES_F_PW] & (mode_cfg == SES_GLOBAL); // [R6]
            end
            exp_fin_q <= ~expo_go & (exp_fin_q
                         | ((ex_q == SES_EX_EXPOSE) & ex_done));
        end
    end

    // global pulses: common reset at start, common transfer at end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pixrst_q <= 1'b0;
            xfer_q   <= 1'b0;
            expact_q <= 1'b0;
        end else begin
            pixrst_q <= expo_go & (mode_q != SES_ROLLING);           // [R1] [R9]
            xfer_q   <= rd_start & (mode_q == SES_GLOBAL);           // [R1]
            expact_q <= (ex_d == SES_EX_EXPOSE) | (ex_d == SES_EX_HOLD);
        end
    end

    // rolling reset walk, one row per line period; it always leads the
    // read walk and the next frame waits for readout, so no row restarts
    // before it was read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            walk_q   <= 1'b0;
            rs_ptr_q <= '0;
            rs_row_q <= '0;
            lrs_q    <= 1'b0;
        end else begin
            lrs_q <= rs_go | (walk_q & lt_done & ~rs_last);          // [R3]
            if (rs_go) begin
                walk_q   <= 1'b1;                                    // [R5]
                rs_row_q <= '0;
                rs_ptr_q <= LW'(1);
            end else if (rs_last) begin
                walk_q <= 1'b0;
            end else if (walk_q & lt_done) begin
                rs_row_q <= rs_ptr_q;                                // [R3]
                rs_ptr_q <= rs_ptr_q + LW'(1);
            end
        end
    end

    // readout walk over every line, active and dummy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_busy_q <= 1'b0;
            rd_ptr_q  <= '0;
            rd_row_q  <= '0;
            lrd_q     <= 1'b0;
            lv_q      <= 1'b0;
        end else begin
            lrd_q <= rd_step;                               // [R2] [R4] [R10]
            if (rd_step) begin
                rd_busy_q <= 1'b1;                                   // [R11]
                rd_row_q  <= rd_row;
                rd_ptr_q  <= LW'(rd_row + LW'(1));
                lv_q      <= in_roi;                                 // [R7]
            end else if (rd_last) begin
                rd_busy_q <= 1'b0;                                   // [R11]
                lv_q      <= 1'b0;
            end
        end
    end

    // flash strobe; outside rolling it is cut when exposure ends
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fl_dly_q <= 1'b0;
            fl_on_q  <= 1'b0;
        end else if (expo_go & fl_en) begin
            fl_dly_q <= roll_now;                                    // [R13]
            fl_on_q  <= ~roll_now;                                   // [R12]
        end else if (fl_done & fl_dly_q) begin
            fl_dly_q <= 1'b0;
            fl_on_q  <= 1'b1;
        end else if (fl_done | (exp_end & ~roll_now & in_exp)) begin
            fl_on_q  <= 1'b0;                                        // [R12]
        end
    end

    // ==========
    // outputs, all straight from flip-flops
    assign pready         = pready_q;
    assign prdata         = prdata_q;
    assign pslverr        = pslverr_q;
    assign pix_reset_all  = pixrst_q;
    assign xfer_all       = xfer_q;
    assign line_reset     = lrs_q;
    assign line_reset_row = rs_row_q;
    assign line_read      = lrd_q;
    assign line_read_row  = rd_row_q;
    assign frame_valid    = rd_busy_q;
    assign line_valid     = lv_q;
    assign flash_strobe   = fl_on_q;
    assign expose_active  = expact_q;
endmodule : ses_seq

//--- test/ses_seq_chk.sv
// ses_seq_chk - concurrent checks on the sequencer ports.
// assumes a bind onto ses_seq that hands on its LW parameter.
`timescale 1ns/1ps
module ses_seq_chk #(
    parameter int LW = 16
) (
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pready,
    input wire logic [31:0]   prdata,
    input wire logic          pix_reset_all,
    input wire logic          line_reset,
    input wire logic [LW-1:0] line_reset_row,
    input wire logic          line_read,
    input wire logic [LW-1:0] line_read_row,
    input wire logic          frame_valid,
    input wire logic          line_valid,
    input wire logic          flash_strobe,
    input wire logic          expose_active
);
    // ==========
    // properties
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [LW-1:0] nxt_q;
    // next row due; a skipped or repeated row shows up here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) nxt_q <= '0;
        else if (line_read) nxt_q <= line_read_row + LW'(1);
        else if (!frame_valid) nxt_q <= '0;
    end
    sequence s_setup; psel && !penable; endsequence
    sequence s_answer; pready; endsequence
    property p_zero_wait; s_setup |=> s_answer; endproperty
    a_zero_wait: assert property (p_zero_wait) else $error("pready late");
    property p_rd_quiet; !pready |-> prdata == 32'h0; endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("prdata idle");
    property p_one_reset; pix_reset_all |-> !line_reset; endproperty
    a_one_reset: assert property (p_one_reset) else $error("mixed reset");
    property p_expose; pix_reset_all |-> ##[0:1] expose_active; endproperty
    a_expose: assert property (p_expose) else $error("no exposure");
    property p_framed; line_read |-> ##[0:1] frame_valid; endproperty
    a_framed: assert property (p_framed) else $error("read unframed");
    property p_row_order; line_read |-> line_read_row == nxt_q; endproperty
    a_row_order: assert property (p_row_order) else $error("row order");
    property p_lv_framed; line_valid |-> frame_valid; endproperty
    a_lv_framed: assert property (p_lv_framed) else $error("lv unframed");
    property p_row_free;
        line_reset && line_read |-> line_reset_row != line_read_row;
    endproperty
    a_row_free: assert property (p_row_free) else $error("row clash");
    property p_flash_in; $rose(flash_strobe) |-> ##[0:1] expose_active; endproperty
    a_flash_in: assert property (p_flash_in) else $error("flash out");
endmodule : ses_seq_chk

//--- test/ses_far_end.sv
// ses_far_end - trigger source and strobe-driven lamp facing the sequencer.
// assumes go is a one-cycle request driven just after a rising edge.
`timescale 1ns/1ps
module ses_far_end (
    input  wire logic       pclk,
    input  wire logic       go,
    input  wire logic [7:0] width,
    input  wire logic       flash_strobe,
    output logic            trig_in,
    output logic [15:0]     lit_cnt
);
    // ==========
    // pulse source and lamp
    logic [7:0] left_q = 8'h00;
    initial lit_cnt = 16'h0000;
    // level held width cycles; width kept above the minimum pulse
    always @(posedge pclk) begin
        left_q <= go ? width : left_q - {7'h00, left_q != 8'h00};
        lit_cnt <= go ? 16'h0 : lit_cnt + {15'h0, flash_strobe};
    end
    assign trig_in = left_q != 8'h00;
endmodule : ses_far_end

//--- test/ses_seq_tb_top.sv
// ses_seq_tb_top - self-checking bench for the exposure sequencer.
// assumes ses_pkg, ses_seq, the far-end model and the checker compiled.
`timescale 1ns/1ps
module ses_seq_tb_top;
    // ==========
    // stimulus and checks
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        go = 0, trig_in, pready, pslverr, pix_reset_all, xfer_all;
    logic        line_reset, line_read, frame_valid, line_valid;
    logic        flash_strobe, expose_active;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, expo;
    logic [15:0] line_reset_row, line_read_row, lit_cnt;
    logic [32:0] exp_q[$];
    logic [31:0] rv[8] = '{32'h0, 32'h3e8, 32'h64, 32'h10, 32'h2, 32'ha,
                           32'h64, 32'h10_0000};
    int          error_cnt = 0, n_checks = 0, cyc = 0, lt, m;
    int          rd_n, rs_n, pr_n, xf_n;
    ses_seq i_ses_seq (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .trig_in(trig_in), .pix_reset_all(pix_reset_all),
        .xfer_all(xfer_all), .line_reset(line_reset),
        .line_reset_row(line_reset_row), .line_read(line_read),
        .line_read_row(line_read_row), .frame_valid(frame_valid),
        .line_valid(line_valid), .flash_strobe(flash_strobe),
        .expose_active(expose_active));
    ses_far_end i_ses_far_end (.pclk(pclk), .go(go), .width(8'h65),
        .flash_strobe(flash_strobe), .trig_in(trig_in), .lit_cnt(lit_cnt));
    initial forever #5 pclk = ~pclk;
    task chk(input logic [32:0] seen, input logic [32:0] want, string what);
        n_checks++;
        if (seen !== want) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask : chk
    task tally_and_finish;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    // request held until pready is seen high at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {psel, penable} <= 2'b00;
    endtask : apb
    task rd(input logic [7:0] a, input logic [32:0] want);
        exp_q.push_back(want);
        apb(1'b0, a, 32'h0);
    endtask : rd
    // monitor: pulse tallies and read data against the oldest note
    always @(negedge pclk) begin
        rd_n += line_read;
        rs_n += line_reset;
        pr_n += pix_reset_all;
        xf_n += xfer_all;
        if (psel && penable && pready && !pwrite)
            chk({pslverr, prdata}, exp_q.pop_front(), "prdata");
    end
    // hang guard, far above the run's few hundred cycles
    always @(posedge pclk) if (++cyc == 40000) begin
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'h0956));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) rd(8'(4 * i), {1'b0, rv[i]});
        rd(8'h30, {1'b1, 32'h0});
        lt = 2 + $urandom % 4;
        expo = 32'(6 * lt + 5) + $urandom % 16;
        apb(1'b1, 8'h08, 32'(lt));
        apb(1'b1, 8'h0c, 32'h4);
        apb(1'b1, 8'h14, 32'h3);
        apb(1'b1, 8'h18, 32'h5);
        apb(1'b1, 8'h04, expo);
        apb(1'b1, 8'h1c, 32'h2_0001);
        rd(8'h24, {1'b0, 32'(6 * lt + 3)});
        rd(8'h28, {1'b0, 32'(6 * lt + 3) + expo});
        for (m = 0; m < 3; m++) begin
            apb(1'b1, 8'h00, 32'h18 | 32'(m) | (m == 2 ? 32'h4 : 32'h0));
            {rd_n, rs_n, pr_n, xf_n} = '0;
            @(posedge pclk) go <= 1'b1;
            @(posedge pclk) go <= 1'b0;
            while (frame_valid !== 1'b1) @(negedge pclk);
            while (frame_valid !== 1'b0 || trig_in !== 1'b0) @(negedge pclk);
            chk(33'(rd_n), 33'h6, "reads");
            chk(33'(rs_n), m == 1 ? 33'h6 : 33'h0, "resets");
            chk(33'(pr_n), m == 1 ? 33'h0 : 33'h1, "pixreset");
            chk(33'(xf_n), m == 0 ? 33'h1 : 33'h0, "xfer");
            chk({17'h0, lit_cnt}, 33'h5, "flash");
        end
        tally_and_finish();
    end
endmodule : ses_seq_tb_top
bind ses_seq ses_seq_chk #(.LW(LW)) i_ses_seq_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .prdata(prdata), .pix_reset_all(pix_reset_all), .line_reset(line_reset),
    .line_reset_row(line_reset_row), .line_read(line_read),
    .line_read_row(line_read_row), .frame_valid(frame_valid),
    .line_valid(line_valid), .flash_strobe(flash_strobe),
    .expose_active(expose_active));
